// ### rtl/bdf_top.sv
// two-queue bidirectional fifo with mailboxes and wishbone registers
//
// Implementation choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - two 36-bit queues, A to B, B to A
// - transfers only on qualified rising port clock
// - port clocks independent; simultaneous write and read
// - two mailboxes, port B width wide
// - mailbox flag rises when new word written
// - master reset zeroes both queue pointers
// - separate master reset per queue
// - standard mode: every word needs a read
// - fall-through: first word shows without read
// - read flag: empty, or output ready
// - write flag: full, or input ready
// - programmable almost-empty and almost-full per queue
// - flags follow the writing or reading port clock
// - four offsets loaded in parallel through port A
// - default thresholds 8, 16 or 64
// - flag selects sampled during master reset
// - idle when nothing happens, wake at once
// - almost-empty low when words at most offset
// - almost-full low when free at most offset
module bdf_top
  import bdf_pkg::*;
#(
  parameter int WIDTH = BDF_DATA_W,
  parameter int AW    = BDF_ADDR_W
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [7:0]       i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [31:0]      i_wb_dat,
  output logic      [31:0]      o_wb_dat,
  output logic                  o_wb_ack,
  input  wire logic             i_side_a_clock,
  input  wire logic             i_side_a_chip_select_n,
  input  wire logic             i_side_a_enable,
  input  wire logic             i_side_a_write,
  input  wire logic             i_side_a_mailbox_sel,
  input  wire logic [WIDTH-1:0] i_side_a_data,
  output logic      [WIDTH-1:0] o_side_a_data,
  output logic                  o_side_a_data_oe,
  output logic                  o_side_a_empty_or_out_ready,
  output logic                  o_side_a_full_or_in_ready,
  output logic                  o_side_a_almost_empty_n,
  output logic                  o_side_a_almost_full_n,
  input  wire logic             i_side_b_clock,
  input  wire logic             i_side_b_chip_select_n,
  input  wire logic             i_side_b_enable,
  input  wire logic             i_side_b_write,
  input  wire logic             i_side_b_mailbox_sel,
  input  wire logic [WIDTH-1:0] i_side_b_data,
  output logic      [WIDTH-1:0] o_side_b_data,
  output logic                  o_side_b_data_oe,
  output logic                  o_side_b_empty_or_out_ready,
  output logic                  o_side_b_full_or_in_ready,
  output logic                  o_side_b_almost_empty_n,
  output logic                  o_side_b_almost_full_n,
  input  wire logic             i_queue_one_master_reset_n,
  input  wire logic             i_queue_two_master_reset_n,
  input  wire logic             i_timing_mode_select,
  input  wire logic             i_flag_select_low,
  input  wire logic             i_flag_select_high,
  output logic                  o_mailbox_one_full_flag,
  output logic                  o_mailbox_two_full_flag,
  output logic                  o_idle
);

  localparam int SW = WIDTH + PIN_DATA;            // pin bundle width
  localparam int CW = AW + 1;                      // count width
  localparam logic [CW-1:0] DEPTH = CW'(1 << AW);  // words per queue

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  logic [SW-1:0]    pin_raw [2];            // raw side pins
  logic [SW-1:0]    pin_s1_q [2];           // first sync stage
  logic [SW-1:0]    pin_s2_q [2];           // second sync stage
  logic [1:0]       clk_prev_q;             // port clock, one later
  logic [MSC_W-1:0] msc_s1_q, msc_s2_q;     // shared control pins
  logic [1:0]       edge_w, sel_w;          // port clock edge, qualified
  logic [1:0]       wr_req, rd_req;         // queue requests per side
  logic [1:0]       mw_req, mr_req;         // mailbox requests per side
  logic [1:0]       qrst;                   // per-queue reset
  logic [1:0]       fetch_a, ov_a, ov_n;    // per-queue fetch, first_word_fall_through word
  logic [CW-1:0]    cnt_a [2], cnt_n [2];   // stored words, now and next
  logic [WIDTH-1:0] din [2];                // synchronised write data
  logic [WIDTH-1:0] rdat_a [2], mbox_a [2]; // queue heads, mailboxes
  logic [1:0]       mflag_a;                // mailbox full flags
  logic             std_q, std_d;           // standard timing mode
  logic [1:0]       fsel_q, fsel_d;         // captured flag select
  logic [CW-1:0]    aeo_q [2], aeo_d [2];   // almost-empty offsets
  logic [CW-1:0]    afo_q [2], afo_d [2];   // almost-full offsets
  bdf_load_type     ld_q, ld_d;             // offset load step
  logic             ld_busy, ld_go;         // load pending, load write
  logic [1:0]       ctrl_q, ctrl_d;         // software queue resets
  logic             ack_q, ack_d;           // wishbone acknowledge
  logic [31:0]      rdat_q, rdat_d;         // wishbone read data
  logic [31:0]      status_w, count_w;      // readable state words
  logic             idle_q, idle_d;         // low-power idle

  assign pin_raw[0] = {i_side_a_data, i_side_a_mailbox_sel, i_side_a_write,
                       i_side_a_enable, i_side_a_chip_select_n,
                       i_side_a_clock};
  assign pin_raw[1] = {i_side_b_data, i_side_b_mailbox_sel, i_side_b_write,
                       i_side_b_enable, i_side_b_chip_select_n,
                       i_side_b_clock};

  // shared control pins cross in two stages before use
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      msc_s1_q <= MSC_RESET_VAL;
      msc_s2_q <= MSC_RESET_VAL;
    end
    else
    begin
      msc_s1_q <= {i_flag_select_high, i_flag_select_low,
                   i_timing_mode_select, i_queue_two_master_reset_n,
                   i_queue_one_master_reset_n};
      msc_s2_q <= msc_s1_q;
    end
  end

  // each queue has its own reset: pin, software bit or system reset
  assign qrst[0] = i_rst | ~msc_s2_q[MSC_QUEUE_ONE_MASTER_RESET] | ctrl_q[CTRL_RST_Q1];
  assign qrst[1] = i_rst | ~msc_s2_q[MSC_QUEUE_TWO_MASTER_RESET] | ctrl_q[CTRL_RST_Q2];

  // fixed encoding: 00 parallel, 01 eight, 10 sixteen, 11 sixty-four
  function automatic logic [CW-1:0] dflt_off(input logic [1:0] fs);
    logic [CW-1:0] v;
    case (fs)
      FS_DEF_8:  v = CW'(OFF_DEF_8);
      FS_DEF_16: v = CW'(OFF_DEF_16);
      FS_DEF_64: v = CW'(OFF_DEF_64);
      default:   v = '0;               // parallel: loaded later
    endcase
    return v;
  endfunction

  assign ld_busy = (ld_q != LD_RUN);
  assign ld_go   = wr_req[0] & ld_busy & ~qrst[0];

  // mode capture and offset programming
  always_comb
  begin
    std_d  = std_q;
    fsel_d = fsel_q;
    ld_d   = ld_q;
    aeo_d  = aeo_q;
    afo_d  = afo_q;
    if (|qrst)
    begin
      // timing and flag selects latched while a reset is held
      std_d  = msc_s2_q[MSC_TMS];
      fsel_d = {msc_s2_q[MSC_FSH], msc_s2_q[MSC_FSL]};
    end
    for (int q = 0; q < 2; q++)
    begin
      if (qrst[q])
      begin
        aeo_d[q] = dflt_off(fsel_d);
        afo_d[q] = dflt_off(fsel_d);
      end
    end
    if (qrst[0])
      ld_d = (fsel_d == FS_PARALLEL) ? LD_X1 : LD_RUN;
    else if (ld_go)
    begin
      // first four port A writes carry the offsets, in this order
      case (ld_q)
        LD_X1:
        begin
          aeo_d[0] = din[0][CW-1:0];
          ld_d     = LD_Y1;
        end
        LD_Y1:
        begin
          afo_d[0] = din[0][CW-1:0];
          ld_d     = LD_X2;
        end
        LD_X2:
        begin
          aeo_d[1] = din[0][CW-1:0];
          ld_d     = LD_Y2;
        end
        LD_Y2:
        begin
          afo_d[1] = din[0][CW-1:0];
          ld_d     = LD_RUN;
        end
        default: ld_d = LD_RUN;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    std_q  <= std_d;
    fsel_q <= fsel_d;
    ld_q   <= ld_d;
    aeo_q  <= aeo_d;
    afo_q  <= afo_d;
  end

  // readable state words
  always_comb
  begin
    status_w                = '0;
    status_w[ST_STD]        = std_q;
    status_w[ST_FSEL +: 2]  = fsel_q;
    status_w[ST_LOAD]       = ld_busy;
    status_w[ST_IDLE]       = idle_q;
    status_w[ST_MBF +: 2]   = mflag_a;
    status_w[ST_OV +: 2]    = ov_a;
    count_w                 = '0;
    count_w[CNT_Q1_POS +: CW] = cnt_a[0];
    count_w[CNT_Q2_POS +: CW] = cnt_a[1];
  end

  // wishbone slave: ack one cycle after the request, unmapped reads zero
  always_comb
  begin
    ack_d  = i_wb_cyc & i_wb_stb & ~ack_q;
    ctrl_d = ctrl_q;
    rdat_d = rdat_q;
    // a write lands at the edge where the master sees ack high
    if (ack_q && i_wb_cyc && i_wb_stb && i_wb_we)
    begin
      if (i_wb_adr == REG_CTRL && i_wb_sel[0])
        ctrl_d = i_wb_dat[1:0];
    end
    if (ack_d && !i_wb_we)
    begin
      case (i_wb_adr)
        REG_CTRL:   rdat_d = {30'h0000_0000, ctrl_q};
        REG_STATUS: rdat_d = status_w;
        REG_COUNT:  rdat_d = count_w;
        default:    rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // idle whenever no port edge is selected and no fetch runs
  always_comb
  begin
    idle_d = ~(|sel_w) & ~(|fetch_a);
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      ctrl_q <= CTRL_RESET_VAL;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
      idle_q <= 1'b1;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
      idle_q <= idle_d;
    end
  end

  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_idle   = idle_q;

  a_idle_wakes: assert property (|sel_w |=> !o_idle)
    else $error("idle flag stayed up after a port transfer");

  // side s writes queue s and reads queue r
  for (genvar s = 0; s < 2; s++)
  begin : g_side
    localparam int R = 1 - s;  // the opposite side
    logic [CW-1:0]    cnt_q, cnt_d;   // words in the array
    logic [AW-1:0]    wp_q, wp_d;     // write pointer
    logic [AW-1:0]    rp_q, rp_d;     // read pointer
    logic             ov_q, ov_d;     // fall-through word shown
    logic             wr_go, fetch, rd_acc;
    logic             ef_q, ef_d, ff_q, ff_d;  // combined flags
    logic             ae_q, ae_d, af_q, af_d;  // almost flags, low true
    logic [CW:0]      held;                    // words of queue r
    logic [WIDTH-1:0] mb_q, mb_d;              // mailbox written here
    logic             mf_q, mf_d;              // its new-mail flag
    logic [WIDTH-1:0] dout_q, dout_d;          // port data register

    // pins cross in two stages; only stage two is looked at
    always_ff @(posedge i_clock)
    begin
      if (i_rst)
      begin
        pin_s1_q[s]   <= '0;
        pin_s2_q[s]   <= '0;
        clk_prev_q[s] <= 1'b0;
      end
      else
      begin
        pin_s1_q[s]   <= pin_raw[s];
        pin_s2_q[s]   <= pin_s1_q[s];
        clk_prev_q[s] <= pin_s2_q[s][PIN_CLK];
      end
    end

    // each port clock is sampled on its own, so the clocks stay free
    assign edge_w[s] = pin_s2_q[s][PIN_CLK] & ~clk_prev_q[s];
    assign sel_w[s]  = edge_w[s] & ~pin_s2_q[s][PIN_CSN]
                       & pin_s2_q[s][PIN_EN];
    assign wr_req[s] = sel_w[s] & pin_s2_q[s][PIN_WR] & ~pin_s2_q[s][PIN_MBX];
    assign rd_req[s] = sel_w[s] & ~pin_s2_q[s][PIN_WR] & ~pin_s2_q[s][PIN_MBX];
    assign mw_req[s] = sel_w[s] & pin_s2_q[s][PIN_WR] & pin_s2_q[s][PIN_MBX];
    assign mr_req[s] = sel_w[s] & ~pin_s2_q[s][PIN_WR] & pin_s2_q[s][PIN_MBX];
    assign din[s]    = pin_s2_q[s][PIN_DATA +: WIDTH];

    // full queue, or on port A a pending offset load, swallows the write
    assign wr_go  = wr_req[s] & (cnt_q != DEPTH) & ~qrst[s]
                    & ~((s == 0) && ld_busy);
    assign rd_acc = rd_req[R] & (std_q ? (cnt_q != '0) : ov_q);
    // fall-through refills the head on its own, standard waits
    assign fetch  = ~qrst[s] & (cnt_q != '0)
                    & (std_q ? rd_req[R] : (~ov_q | rd_req[R]));

    // queue pointers and count
    always_comb
    begin
      cnt_d = cnt_q;
      wp_d  = wp_q;
      rp_d  = rp_q;
      ov_d  = ov_q;
      if (qrst[s])
      begin
        cnt_d = '0;
        wp_d  = '0;
        rp_d  = '0;
        ov_d  = 1'b0;
      end
      else
      begin
        if (wr_go)
          wp_d = wp_q + 1'b1;
        if (fetch)
          rp_d = rp_q + 1'b1;
        cnt_d = cnt_q + CW'(wr_go) - CW'(fetch);
        ov_d  = ~std_q & (fetch | (ov_q & ~rd_acc));
      end
    end

    // flags change only on the owning port's clock edge or a queue reset
    always_comb
    begin
      held = {1'b0, cnt_n[R]} + (CW+1)'(ov_n[R]);
      ef_d = ef_q;
      ae_d = ae_q;
      ff_d = ff_q;
      af_d = af_q;
      if (qrst[R])
      begin
        ef_d = 1'b0;
        ae_d = 1'b0;
      end
      else if (edge_w[s])
      begin
        ef_d = std_q ? (cnt_n[R] != '0) : ov_n[R];
        ae_d = held > {1'b0, aeo_d[R]};
      end
      if (qrst[s])
      begin
        ff_d = 1'b1;
        af_d = 1'b1;
      end
      else if (edge_w[s])
      begin
        ff_d = (cnt_n[s] != DEPTH);
        af_d = (DEPTH - cnt_n[s]) > afo_d[s];
      end
    end

    // mailbox bypass; a new word beats a clear in the same cycle
    always_comb
    begin
      mb_d = mb_q;
      mf_d = mf_q;
      if (qrst[s])
      begin
        mb_d = '0;
        mf_d = 1'b0;
      end
      else
      begin
        if (mw_req[s])
          mb_d = din[s];
        mf_d = mw_req[s] | (mf_q & ~mr_req[R]);
      end
      dout_d = pin_s2_q[s][PIN_MBX] ? mbox_a[R] : rdat_a[R];
    end

    always_ff @(posedge i_clock)
    begin
      cnt_q  <= cnt_d;
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      ov_q   <= ov_d;
      ef_q   <= ef_d;
      ae_q   <= ae_d;
      ff_q   <= ff_d;
      af_q   <= af_d;
      mb_q   <= mb_d;
      mf_q   <= mf_d;
      dout_q <= i_rst ? '0 : dout_d;
    end

    assign cnt_a[s]   = cnt_q;
    assign cnt_n[s]   = cnt_d;
    assign ov_a[s]    = ov_q;
    assign ov_n[s]    = ov_d;
    assign fetch_a[s] = fetch;
    assign mbox_a[s]  = mb_q;
    assign mflag_a[s] = mf_q;

    // one storage array per direction
    bdf_ram #(.WIDTH(WIDTH), .AW(AW)) u_ram (
      .i_clock   (i_clock),
      .i_rst     (i_rst),
      .i_wr_en   (wr_go),
      .i_wr_addr (wp_q),
      .i_wr_data (din[s]),
      .i_rd_en   (fetch),
      .i_rd_addr (rp_q),
      .o_rd_data (rdat_a[s])
    );

    sequence s_head_empty;
      !std_q && !ov_q && cnt_q != '0;
    endsequence
    sequence s_head_lands;
      ##1 ov_q;
    endsequence

    a_reset_ptrs: assert property (qrst[s] |=> wp_q == '0 && rp_q == '0)
      else $error("pointers not at first location after reset");
    a_full_write: assert property (disable iff (qrst[s])
      cnt_q == DEPTH && !fetch |=> cnt_q == DEPTH && $stable(wp_q))
      else $error("write into a full queue moved its pointer");
    a_first_word_fall_through_falls: assert property (disable iff (qrst[s])
      s_head_empty |-> s_head_lands)
      else $error("first word did not fall through");
    a_std_holds: assert property (disable iff (qrst[s])
      std_q && !rd_req[R] |=> $stable(rdat_a[s]))
      else $error("standard mode head moved without a read");
    a_queue_indep: assert property (disable iff (qrst[R])
      qrst[s] && !fetch_a[R] && !wr_req[R] |=> $stable(cnt_a[R]))
      else $error("reset of one queue changed the other");
    a_read_flag: assert property (disable iff (qrst[R])
      edge_w[s] |=> ef_q == (std_q ? cnt_a[R] != '0 : ov_a[R]))
      else $error("empty or output-ready flag wrong");
    a_write_flag: assert property (disable iff (qrst[s])
      edge_w[s] |=> ff_q == (cnt_a[s] != DEPTH))
      else $error("full or input-ready flag wrong");
    a_almost_empty: assert property (disable iff (qrst[R])
      edge_w[s] |=> ae_q == ({1'b0, cnt_a[R]} + (CW+1)'(ov_a[R])
                             > {1'b0, aeo_q[R]}))
      else $error("almost-empty flag does not match fill level");
    a_almost_full: assert property (disable iff (qrst[s])
      edge_w[s] |=> af_q == ((DEPTH - cnt_a[s]) > afo_q[s]))
      else $error("almost-full flag does not match free space");
    a_mail_flag: assert property (disable iff (qrst[s])
      mw_req[s] |=> mf_q ##1 (mf_q || $past(mr_req[R])))
      else $error("mailbox flag not set by a mailbox write");
  end

  assign o_side_a_data               = g_side[0].dout_q;
  assign o_side_b_data               = g_side[1].dout_q;
  assign o_side_a_data_oe            = ~pin_s2_q[0][PIN_CSN] & ~pin_s2_q[0][PIN_WR];
  assign o_side_b_data_oe            = ~pin_s2_q[1][PIN_CSN] & ~pin_s2_q[1][PIN_WR];
  assign o_side_a_empty_or_out_ready = g_side[0].ef_q;
  assign o_side_b_empty_or_out_ready = g_side[1].ef_q;
  assign o_side_a_full_or_in_ready   = g_side[0].ff_q;
  assign o_side_b_full_or_in_ready   = g_side[1].ff_q;
  assign o_side_a_almost_empty_n     = g_side[0].ae_q;
  assign o_side_b_almost_empty_n     = g_side[1].ae_q;
  assign o_side_a_almost_full_n      = g_side[0].af_q;
  assign o_side_b_almost_full_n      = g_side[1].af_q;
  assign o_mailbox_one_full_flag     = mflag_a[0];
  assign o_mailbox_two_full_flag     = mflag_a[1];

endmodule

// ### rtl/bdf_pkg.sv
// shared constants and types for the two-queue bidirectional fifo
package bdf_pkg;

  // word width and per-queue address width (1k words)
  localparam int BDF_DATA_W = 36;
  localparam int BDF_ADDR_W = 10;

  // wishbone register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT  = 8'h08;

  // control register: one software reset bit per queue
  localparam int         CTRL_RST_Q1    = 0;
  localparam int         CTRL_RST_Q2    = 1;
  localparam logic [1:0] CTRL_RESET_VAL = 2'h0;

  // status register fields
  localparam int ST_STD  = 0;  // standard timing mode
  localparam int ST_FSEL = 1;  // captured flag select, two bits
  localparam int ST_LOAD = 3;  // offset load still waiting
  localparam int ST_IDLE = 4;  // low-power idle
  localparam int ST_MBF  = 5;  // mailbox flags, two bits
  localparam int ST_OV   = 7;  // fall-through word present, two bits

  // count register: stored words of each queue
  localparam int CNT_Q1_POS = 0;
  localparam int CNT_Q2_POS = 16;

  // bit positions in a side's synchronised pin bundle
  localparam int PIN_CLK  = 0;
  localparam int PIN_CSN  = 1;
  localparam int PIN_EN   = 2;
  localparam int PIN_WR   = 3;
  localparam int PIN_MBX  = 4;
  localparam int PIN_DATA = 5;

  // bit positions in the shared control pin bundle
  localparam int         MSC_QUEUE_ONE_MASTER_RESET      = 0;
  localparam int         MSC_QUEUE_TWO_MASTER_RESET      = 1;
  localparam int         MSC_TMS       = 2;
  localparam int         MSC_FSL       = 3;
  localparam int         MSC_FSH       = 4;
  localparam int         MSC_W         = 5;
  localparam logic [4:0] MSC_RESET_VAL = 5'h03;

  // flag select encodings {high, low}
  localparam logic [1:0] FS_PARALLEL = 2'h0;
  localparam logic [1:0] FS_DEF_8    = 2'h1;
  localparam logic [1:0] FS_DEF_16   = 2'h2;
  localparam logic [1:0] FS_DEF_64   = 2'h3;

  // default threshold distances in locations
  localparam int OFF_DEF_8  = 8;
  localparam int OFF_DEF_16 = 16;
  localparam int OFF_DEF_64 = 64;

  // parallel offset load sequence, gray along the path
  typedef enum logic [2:0] {
    LD_X1  = 3'h0,
    LD_Y1  = 3'h1,
    LD_X2  = 3'h3,
    LD_Y2  = 3'h2,
    LD_RUN = 3'h6
  } bdf_load_type;

endpackage

// ### rtl/bdf_ram.sv
// storage array of one queue with a registered read port
`timescale 1ns/1ps
module bdf_ram
  import bdf_pkg::*;
#(
  parameter int WIDTH = BDF_DATA_W,
  parameter int AW    = BDF_ADDR_W
)(
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic             i_wr_en,
  input  wire logic [AW-1:0]    i_wr_addr,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_rd_en,
  input  wire logic [AW-1:0]    i_rd_addr,
  output logic      [WIDTH-1:0] o_rd_data
);

  logic [WIDTH-1:0] mem_q [1<<AW];  // word storage, no reset
  logic [WIDTH-1:0] rd_data_d;      // next read register value

  // read register only moves on a fetch
  always_comb
  begin
    rd_data_d = i_rd_en ? mem_q[i_rd_addr] : o_rd_data;
  end

  // array write, kept free of reset so it maps to ram
  always_ff @(posedge i_clock)
  begin
    if (i_wr_en)
      mem_q[i_wr_addr] <= i_wr_data;
  end

  // read data register
  always_ff @(posedge i_clock)
  begin
    if (i_rst)
      o_rd_data <= '0;
    else
      o_rd_data <= rd_data_d;
  end

endmodule

// ### bench/bdf_port_agent.sv
// partner model: a synchronous host on one fifo port
`timescale 1ns/1ps
module bdf_port_agent (
  input  wire logic   i_clock,
  output logic        o_clk,
  output logic        o_csn,
  output logic        o_en,
  output logic        o_wr,
  output logic        o_mbx,
  output logic [35:0] o_dat
);
  // idle: port clock parked low, port deselected
  initial
  begin
    {o_clk, o_csn, o_en, o_wr, o_mbx} = 5'h08;
    o_dat = 36'h0;
  end
  // one qualified edge; pins held 4 cycles around it
  task automatic xfer(input logic w, input logic m, input logic [35:0] d);
    begin
      @(posedge i_clock);
      {o_csn, o_en, o_wr, o_mbx} <= {2'h1, w, m};
      o_dat <= d;
      repeat (4) @(posedge i_clock);
      o_clk <= 1'b1;
      repeat (4) @(posedge i_clock);
      o_clk <= 1'b0;
      o_csn <= 1'b1;
      // released bus flips so stale data never looks valid
      o_dat <= ~d;
      repeat (4) @(posedge i_clock);
    end
  endtask
endmodule

// ### bench/bdf_tb_top.sv
// self-checking bench for the two-queue fifo
`timescale 1ns/1ps
module bdf_tb_top;
  import bdf_pkg::*;
  // pins driven by the bench and the two port hosts
  logic i_clock, i_rst, i_wb_cyc, i_wb_stb, i_wb_we;
  logic [7:0] i_wb_adr;
  logic [31:0] i_wb_dat, rdat;
  logic i_side_a_clock, i_side_a_chip_select_n, i_side_a_enable;
  logic i_side_a_write, i_side_a_mailbox_sel;
  logic i_side_b_clock, i_side_b_chip_select_n, i_side_b_enable;
  logic i_side_b_write, i_side_b_mailbox_sel;
  logic [35:0] i_side_a_data, i_side_b_data;
  logic i_queue_one_master_reset_n, i_queue_two_master_reset_n;
  logic i_timing_mode_select, i_flag_select_low, i_flag_select_high;
  // design outputs
  wire [31:0] o_wb_dat;
  wire [35:0] o_side_a_data, o_side_b_data;
  wire o_wb_ack, o_side_a_data_oe, o_side_b_data_oe, o_idle;
  wire o_side_a_empty_or_out_ready, o_side_a_full_or_in_ready;
  wire o_side_b_empty_or_out_ready, o_side_b_full_or_in_ready;
  wire o_side_a_almost_empty_n, o_side_a_almost_full_n;
  wire o_side_b_almost_empty_n, o_side_b_almost_full_n;
  wire o_mailbox_one_full_flag, o_mailbox_two_full_flag;
  int bad_count, n_tests, i;
  bdf_top i_bdf_top (.i_clock, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_sel(4'hF), .i_wb_dat, .o_wb_dat, .o_wb_ack,
    .i_side_a_clock, .i_side_a_chip_select_n, .i_side_a_enable,
    .i_side_a_write, .i_side_a_mailbox_sel, .i_side_a_data, .o_side_a_data,
    .o_side_a_data_oe, .o_side_a_empty_or_out_ready,
    .o_side_a_full_or_in_ready, .o_side_a_almost_empty_n,
    .o_side_a_almost_full_n, .i_side_b_clock, .i_side_b_chip_select_n,
    .i_side_b_enable, .i_side_b_write, .i_side_b_mailbox_sel,
    .i_side_b_data, .o_side_b_data, .o_side_b_data_oe,
    .o_side_b_empty_or_out_ready, .o_side_b_full_or_in_ready,
    .o_side_b_almost_empty_n, .o_side_b_almost_full_n,
    .i_queue_one_master_reset_n, .i_queue_two_master_reset_n,
    .i_timing_mode_select, .i_flag_select_low, .i_flag_select_high,
    .o_mailbox_one_full_flag, .o_mailbox_two_full_flag, .o_idle);
  bdf_port_agent i_bdf_port_agent_a (.i_clock, .o_clk(i_side_a_clock),
    .o_csn(i_side_a_chip_select_n), .o_en(i_side_a_enable),
    .o_wr(i_side_a_write), .o_mbx(i_side_a_mailbox_sel),
    .o_dat(i_side_a_data));
  bdf_port_agent i_bdf_port_agent_b (.i_clock, .o_clk(i_side_b_clock),
    .o_csn(i_side_b_chip_select_n), .o_en(i_side_b_enable),
    .o_wr(i_side_b_write), .o_mbx(i_side_b_mailbox_sel),
    .o_dat(i_side_b_data));
  // verdict and end of run
  task automatic end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // one compare, counted
  task automatic chk(input string s, input logic [35:0] e, input logic [35:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        bad_count++;
        $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
    end
  endtask
  // classic single wishbone cycle; waits for ack, bounded
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge i_clock);
      {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'h3, w};
      i_wb_adr <= a;
      i_wb_dat <= d;
      @(posedge i_clock);
      for (n = 0; n < 50 && o_wb_ack !== 1'b1; n++)
        @(posedge i_clock);
      if (n == 50)
      begin
        bad_count++;
        end_sim();
      end
      rdat = o_wb_dat;
      {i_wb_cyc, i_wb_stb} <= 2'h0;
    end
  endtask
  always #5 i_clock = ~i_clock;
  initial
  begin
    {i_clock, i_rst, i_wb_cyc, i_wb_stb, i_wb_we} = 5'h08;
    {i_wb_adr, i_wb_dat, bad_count, n_tests} = '0;
    {i_queue_one_master_reset_n, i_queue_two_master_reset_n} = 2'h0;
    // standard mode, default offset of 8, held across queue reset
    {i_timing_mode_select, i_flag_select_high, i_flag_select_low} = 3'h5;
    repeat (5) @(posedge i_clock);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clock);
    {i_queue_one_master_reset_n, i_queue_two_master_reset_n} <= 2'h3;
    repeat (4) @(posedge i_clock);
    chk("idle", 36'h1, o_idle);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("std mode", 36'h1, rdat[ST_STD]);
    chk("flag sel", FS_DEF_8, rdat[2:1]);
    wb(1'b0, 8'h0C, 32'hFFFF_FFFF);
    chk("unmapped", 36'h0, rdat);
    for (i = 0; i < 3; i++)
      i_bdf_port_agent_a.xfer(1'b1, 1'b0, 36'hA_0000_0000 + i);
    wb(1'b0, REG_COUNT, 32'h0);
    chk("count q1", 36'h3, rdat[10:0]);
    chk("in ready a", 36'h1, o_side_a_full_or_in_ready);
    chk("almost full a", 36'h1, o_side_a_almost_full_n);
    for (i = 0; i < 3; i++)
    begin
      i_bdf_port_agent_b.xfer(1'b0, 1'b0, 36'h0);
      chk("q1 word", 36'hA_0000_0000 + i, o_side_b_data);
      chk("almost empty b", 36'h0, o_side_b_almost_empty_n);
    end
    // read from an empty queue must leave pointers alone
    i_bdf_port_agent_b.xfer(1'b0, 1'b0, 36'h0);
    chk("empty flag b", 36'h0, o_side_b_empty_or_out_ready);
    chk("held word", 36'hA_0000_0002, o_side_b_data);
    i_bdf_port_agent_b.xfer(1'b1, 1'b0, 36'h5_B5B5_B5B5);
    i_bdf_port_agent_a.xfer(1'b0, 1'b0, 36'h0);
    chk("q2 word", 36'h5_B5B5_B5B5, o_side_a_data);
    i_bdf_port_agent_a.xfer(1'b1, 1'b1, 36'h9_1234_5678);
    chk("mail flag set", 36'h1, o_mailbox_one_full_flag);
    i_bdf_port_agent_b.xfer(1'b0, 1'b1, 36'h0);
    chk("mail word", 36'h9_1234_5678, o_side_b_data);
    chk("mail flag clr", 36'h0, o_mailbox_one_full_flag);
    i_bdf_port_agent_a.xfer(1'b1, 1'b0, 36'h7);
    i_bdf_port_agent_b.xfer(1'b1, 1'b0, 36'h9);
    // reset queue two alone; queue one keeps its word
    i_queue_two_master_reset_n <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_queue_two_master_reset_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    wb(1'b0, REG_COUNT, 32'h0);
    chk("q1 kept", 36'h1, rdat[10:0]);
    chk("q2 cleared", 36'h0, rdat[26:16]);
    // fall-through with parallel offsets, via software reset of queue one
    {i_timing_mode_select, i_flag_select_high, i_flag_select_low} <= 3'h0;
    repeat (4) @(posedge i_clock);
    wb(1'b1, REG_CTRL, 32'h1);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", 36'h1, rdat);
    wb(1'b1, REG_CTRL, 32'h0);
    for (i = 0; i < 4; i++)
      i_bdf_port_agent_a.xfer(1'b1, 1'b0, 36'h2);
    i_bdf_port_agent_a.xfer(1'b1, 1'b0, 36'h3_0000_00C1);
    chk("first_word_fall_through word", 36'h3_0000_00C1, o_side_b_data);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("first_word_fall_through mode", 36'h0, rdat[ST_STD]);
    chk("load done", 36'h0, rdat[ST_LOAD]);
    chk("first_word_fall_through head", 36'h1, rdat[ST_OV]);
    end_sim();
  end
endmodule
